// *** hw/bss_sequencer.sv ***
// Holding brake and motor power sequencer of the servo drive
`timescale 1ns/1ps
`include "bss_regs.svh"
module bss_sequencer #(
  parameter logic [15:0] MAX_SPEED_RPM  = 16'h1770,
  parameter logic [15:0] ZERO_SPEED_RPM = 16'h0014,
  parameter int          STEP_CYCLES    = `BSS_STEP_NS / `BSS_CLK_NS
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Host commands
  input  wire logic        servoOnCmd,
  input  wire logic        servoOffCmd,
  input  wire logic        cfgRestart,
  // Alarm and drive conditions
  input  wire logic        coastAlarmGroup,
  input  wire logic        selectableAlarmGroup,
  input  wire logic        overtravel,
  input  wire logic        torqueCtrl,
  // Speed feedback, signed rpm
  input  wire logic [15:0] motorSpeed,
  // Parameter write port
  input  wire logic        prmWrEn,
  input  wire logic [1:0]  prmWrIdx,
  input  wire logic [15:0] prmWrData,
  // Parameter read port
  input  wire logic [1:0]  prmRdIdx,
  output logic      [15:0] prmRdData,
  // Drive outputs
  output logic             brakeReleaseOut,
  output logic             motorPowerOn,
  output logic             zeroSpeedRef,
  output logic      [4:0]  seqState
);

  // ========================================================================
  // Declarations
  bss_pkg::bss_state_t state_r;
  bss_pkg::bss_state_t state_nxt;

  logic [15:0] brakeToPoweroffDelay_r;
  logic [15:0] brakeEngageSpeedLevel_r;
  logic [15:0] runningBrakeWaitTime_r;
  logic [15:0] alarmStopMethodSelect_r;
  logic [3:0]  alarmStopMethodDigit_r;
  logic        started_r;
  logic [15:0] stepCnt_r;
  logic        brakeRelease_nxt;
  logic        powerOn_nxt;
  logic        zeroRef_nxt;
  logic [15:0] absSpeed;
  logic [15:0] engageLevel;
  logic        belowLevel;
  logic        motorStopped;
  logic        alarmAny;
  logic        alarmCoasts;
  logic        stateChange;
  logic        stepTick;
  logic        stepDone;
  logic [15:0] wrDelay;
  logic [15:0] wrLevel;
  logic [15:0] wrWait;

  // ========================================================================
  // Speed conditions
  assign absSpeed = motorSpeed[15] ? 16'(~motorSpeed + 16'h0001)
                                   : motorSpeed;

  assign engageLevel = (brakeEngageSpeedLevel_r > MAX_SPEED_RPM)
                     ? MAX_SPEED_RPM
                     : brakeEngageSpeedLevel_r;

  assign belowLevel   = absSpeed < engageLevel;
  assign motorStopped = absSpeed <= ZERO_SPEED_RPM;

  // ========================================================================
  // Alarm classification
  assign alarmAny = coastAlarmGroup | selectableAlarmGroup;

  assign alarmCoasts = coastAlarmGroup
                     | torqueCtrl
                     | (alarmStopMethodDigit_r == `BSS_STOP_COAST);

  // ========================================================================
  // Write value limiting
  assign wrDelay = (prmWrData > `BSS_BRK_DLY_MAX) ? `BSS_BRK_DLY_MAX
                                                 : prmWrData;

  assign wrLevel = (prmWrData > `BSS_BRK_SPD_MAX) ? `BSS_BRK_SPD_MAX
                                                 : prmWrData;

  assign wrWait = (prmWrData < `BSS_RUN_WAIT_MIN) ? `BSS_RUN_WAIT_MIN
                : (prmWrData > `BSS_RUN_WAIT_MAX) ? `BSS_RUN_WAIT_MAX
                : prmWrData;

  // ========================================================================
  // Parameter registers, live at once except the stop method digit, taken on restart
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      brakeToPoweroffDelay_r  <= `BSS_RST_BRK_DLY;
      brakeEngageSpeedLevel_r <= `BSS_RST_BRK_SPD;
      runningBrakeWaitTime_r  <= `BSS_RST_RUN_WAIT;
      alarmStopMethodSelect_r <= `BSS_RST_STOP_SEL;
    end
    else if (prmWrEn)
    begin
      if (prmWrIdx == `BSS_IDX_BRK_DLY)
      begin
        brakeToPoweroffDelay_r <= wrDelay;
      end
      else if (prmWrIdx == `BSS_IDX_BRK_SPD)
      begin
        brakeEngageSpeedLevel_r <= wrLevel;
      end
      else if (prmWrIdx == `BSS_IDX_RUN_WAIT)
      begin
        runningBrakeWaitTime_r <= wrWait;
      end
      else
      begin
        alarmStopMethodSelect_r <= prmWrData;
      end
    end
  end

  // ========================================================================
  // Stop method digit, taken only after reset release or restart
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      started_r              <= 1'b0;
      alarmStopMethodDigit_r <= `BSS_STOP_ZERO;
    end
    else
    begin
      started_r <= 1'b1;
      if (!started_r || cfgRestart)
      begin
        alarmStopMethodDigit_r <= alarmStopMethodSelect_r
          [`BSS_STOP_DIG_MSB:`BSS_STOP_DIG_LSB];
      end
    end
  end

  // ========================================================================
  // Parameter read port
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      prmRdData <= 16'h0000;
    end
    else if (prmRdIdx == `BSS_IDX_BRK_DLY)
    begin
      prmRdData <= brakeToPoweroffDelay_r;
    end
    else if (prmRdIdx == `BSS_IDX_BRK_SPD)
    begin
      prmRdData <= brakeEngageSpeedLevel_r;
    end
    else if (prmRdIdx == `BSS_IDX_RUN_WAIT)
    begin
      prmRdData <= runningBrakeWaitTime_r;
    end
    else
    begin
      prmRdData <= alarmStopMethodSelect_r;
    end
  end

  // ========================================================================
  // Step timer, restarted on each state entry
  assign stateChange = state_nxt != state_r;
  assign stepDone    = stepCnt_r == 16'h0000;

  bss_tick_gen #(
    .TICK_CYCLES (STEP_CYCLES)
  ) u_tick (
    .mclk    (mclk),
    .resetn  (resetn),
    .restart (stateChange),
    .tick    (stepTick)
  );

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      stepCnt_r <= 16'h0000;
    end
    else if (stateChange && state_nxt == bss_pkg::BSS_STOP_DLY)
    begin
      stepCnt_r <= brakeToPoweroffDelay_r;
    end
    else if (stateChange && state_nxt == bss_pkg::BSS_COAST)
    begin
      stepCnt_r <= runningBrakeWaitTime_r;
    end
    else if (stepTick && !stepDone)
    begin
      stepCnt_r <= stepCnt_r - 16'h0001;
    end
  end

  // ========================================================================
  // State sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      bss_pkg::BSS_IDLE:
      begin
        if (servoOnCmd && !alarmAny)
        begin
          state_nxt = bss_pkg::BSS_RUN;
        end
      end
      bss_pkg::BSS_RUN:
      begin
        if (alarmAny)
        begin
          if (motorStopped)
          begin
            state_nxt = bss_pkg::BSS_IDLE;
          end
          else if (alarmCoasts)
          begin
            state_nxt = bss_pkg::BSS_COAST;
          end
          else
          begin
            state_nxt = bss_pkg::BSS_ZERO;
          end
        end
        else if (servoOffCmd)
        begin
          if (!motorStopped)
          begin
            state_nxt = bss_pkg::BSS_COAST;
          end
          else if (brakeToPoweroffDelay_r == `BSS_RST_BRK_DLY)
          begin
            state_nxt = bss_pkg::BSS_IDLE;
          end
          else
          begin
            state_nxt = bss_pkg::BSS_STOP_DLY;
          end
        end
      end
      bss_pkg::BSS_STOP_DLY:
      begin
        if (alarmAny || stepDone)
        begin
          state_nxt = bss_pkg::BSS_IDLE;
        end
      end
      bss_pkg::BSS_ZERO:
      begin
        if (coastAlarmGroup || torqueCtrl)
        begin
          state_nxt = bss_pkg::BSS_COAST;
        end
        else if (motorStopped)
        begin
          state_nxt = bss_pkg::BSS_IDLE;
        end
      end
      bss_pkg::BSS_COAST:
      begin
        if (belowLevel || stepDone)
        begin
          state_nxt = bss_pkg::BSS_IDLE;
        end
      end
      default:
      begin
        state_nxt = bss_pkg::BSS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= bss_pkg::BSS_IDLE;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ========================================================================
  // Output decode from the next state, so outputs move with the state
  always_comb
  begin
    brakeRelease_nxt = 1'b0;
    powerOn_nxt      = 1'b0;
    zeroRef_nxt      = 1'b0;
    case (state_nxt)
      bss_pkg::BSS_RUN:
      begin
        brakeRelease_nxt = 1'b1;
        powerOn_nxt      = 1'b1;
      end
      bss_pkg::BSS_STOP_DLY:
      begin
        powerOn_nxt      = 1'b1;
      end
      bss_pkg::BSS_ZERO:
      begin
        brakeRelease_nxt = 1'b1;
        powerOn_nxt      = 1'b1;
        zeroRef_nxt      = 1'b1;
      end
      bss_pkg::BSS_COAST:
      begin
        brakeRelease_nxt = 1'b1;
      end
      default: brakeRelease_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      brakeReleaseOut <= 1'b0;
      motorPowerOn    <= 1'b0;
      zeroSpeedRef    <= 1'b0;
    end
    else
    begin
      brakeReleaseOut <= brakeRelease_nxt;
      motorPowerOn    <= powerOn_nxt;
      zeroSpeedRef    <= zeroRef_nxt;
    end
  end

  assign seqState = state_r;

endmodule : bss_sequencer

// *** hw/bss_regs.svh ***
// Register indices, field layout, reset values and timing of the sequencer
`ifndef BSS_REGS_SVH
`define BSS_REGS_SVH

// ==========================================================================
// Parameter register indices
`define BSS_IDX_BRK_DLY   2'h0
`define BSS_IDX_BRK_SPD   2'h1
`define BSS_IDX_RUN_WAIT  2'h2
`define BSS_IDX_STOP_SEL  2'h3

// ==========================================================================
// Reset values
`define BSS_RST_BRK_DLY   16'h0000
`define BSS_RST_BRK_SPD   16'h0064
`define BSS_RST_RUN_WAIT  16'h0032
`define BSS_RST_STOP_SEL  16'h0000

// ==========================================================================
// Setting ranges
`define BSS_BRK_DLY_MAX   16'h0032
`define BSS_BRK_SPD_MAX   16'h2710
`define BSS_RUN_WAIT_MIN  16'h000a
`define BSS_RUN_WAIT_MAX  16'h0064

// ==========================================================================
// Stop method digit field and its codes
`define BSS_STOP_DIG_MSB  7
`define BSS_STOP_DIG_LSB  4
`define BSS_STOP_ZERO     4'h0
`define BSS_STOP_COAST    4'h1

// ==========================================================================
// Timing: one setting step in ns and the clock period in ns
`define BSS_STEP_NS       10000000
`define BSS_CLK_NS        8

`endif

// *** hw/bss_pkg.sv ***
// Types shared by the brake and stop sequencer
package bss_pkg;

  // ========================================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    BSS_IDLE     = 5'h01,
    BSS_RUN      = 5'h02,
    BSS_STOP_DLY = 5'h04,
    BSS_ZERO     = 5'h08,
    BSS_COAST    = 5'h10
  } bss_state_t;

endpackage : bss_pkg

// *** hw/bss_tick_gen.sv ***
// Restartable divider giving one-cycle pulses at the setting step rate
`timescale 1ns/1ps
module bss_tick_gen #(
  parameter int TICK_CYCLES = 1250000
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic resetn,
  // Control
  input  wire logic restart,
  // Step pulse
  output logic      tick
);

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  logic [CW-1:0] count_r;

  // ========================================================================
  // Divider, restarted so a full step passes before the first pulse
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      count_r <= '0;
      tick    <= 1'b0;
    end
    else if (restart)
    begin
      count_r <= '0;
      tick    <= 1'b0;
    end
    else if (count_r == LAST)
    begin
      count_r <= '0;
      tick    <= 1'b1;
    end
    else
    begin
      count_r <= count_r + 1'b1;
      tick    <= 1'b0;
    end
  end

endmodule : bss_tick_gen

// *** sim/bss_props.sv ***
// Concurrent checks on the sequencer ports
`timescale 1ns/1ps
`include "bss_regs.svh"
module bss_props #(
  parameter logic [15:0] MAX_SPEED_RPM  = 16'h1770,
  parameter logic [15:0] ZERO_SPEED_RPM = 16'h0014
) (
  // Clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // Commands and conditions
  input wire logic        servoOnCmd,
  input wire logic        servoOffCmd,
  input wire logic        coastAlarmGroup,
  input wire logic        selectableAlarmGroup,
  input wire logic        overtravel,
  input wire logic        torqueCtrl,
  input wire logic [15:0] motorSpeed,
  // Parameter writes
  input wire logic        prmWrEn,
  input wire logic [1:0]  prmWrIdx,
  input wire logic [15:0] prmWrData,
  // Outputs
  input wire logic        brakeReleaseOut,
  input wire logic        motorPowerOn,
  input wire logic        zeroSpeedRef,
  input wire logic [4:0]  seqState
);
  // ==========================================================================
  // Speed magnitude, tracked level, states
  logic [15:0] mag;
  logic [15:0] lim;
  logic [15:0] level_r;
  logic        alm;
  logic        sIdle;
  logic        sRun;
  logic        sZero;
  logic        sCoast;
  assign mag = motorSpeed[15] ? -motorSpeed : motorSpeed;
  assign lim = (level_r < MAX_SPEED_RPM) ? level_r : MAX_SPEED_RPM;
  assign alm = coastAlarmGroup | selectableAlarmGroup;
  assign sIdle = seqState == bss_pkg::BSS_IDLE;
  assign sRun = seqState == bss_pkg::BSS_RUN;
  assign sZero = seqState == bss_pkg::BSS_ZERO;
  assign sCoast = seqState == bss_pkg::BSS_COAST;
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn)
      level_r <= `BSS_RST_BRK_SPD;
    else if (prmWrEn && prmWrIdx == `BSS_IDX_BRK_SPD)
      level_r <= (prmWrData > `BSS_BRK_SPD_MAX) ? `BSS_BRK_SPD_MAX : prmWrData;

  // ==========================================================================
  // Assertions
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_on;
    sIdle && servoOnCmd && !alm |=> sRun && brakeReleaseOut && motorPowerOn;
  endproperty
  a_on: assert property (p_on) else $error("servo on");
  property p_ot;
    sRun && overtravel |-> brakeReleaseOut;
  endproperty
  a_ot: assert property (p_ot) else $error("overtravel");
  property p_off;
    sRun && servoOffCmd && !alm && mag <= ZERO_SPEED_RPM |=> !brakeReleaseOut;
  endproperty
  a_off: assert property (p_off) else $error("stopped off");
  property p_alm;
    sRun && coastAlarmGroup |=> !motorPowerOn ##1 !motorPowerOn;
  endproperty
  a_alm: assert property (p_alm) else $error("alarm power");
  property p_zero;
    sZero |-> zeroSpeedRef && motorPowerOn && brakeReleaseOut;
  endproperty
  a_zero: assert property (p_zero) else $error("zero stop");
  property p_tq;
    sRun && selectableAlarmGroup && torqueCtrl && mag > ZERO_SPEED_RPM
      |=> sCoast && !zeroSpeedRef;
  endproperty
  a_tq: assert property (p_tq) else $error("torque");
  property p_spd;
    sCoast && mag < lim |=> sIdle && !brakeReleaseOut;
  endproperty
  a_spd: assert property (p_spd) else $error("level");
  property p_halt;
    sZero && mag <= ZERO_SPEED_RPM && !coastAlarmGroup && !torqueCtrl
      |=> !brakeReleaseOut && !motorPowerOn;
  endproperty
  a_halt: assert property (p_halt) else $error("halt");
endmodule : bss_props

bind bss_sequencer bss_props #(
  .MAX_SPEED_RPM (MAX_SPEED_RPM),
  .ZERO_SPEED_RPM(ZERO_SPEED_RPM)
) u_bss_props (
  .mclk(mclk), .resetn(resetn), .servoOnCmd(servoOnCmd),
  .servoOffCmd(servoOffCmd), .coastAlarmGroup(coastAlarmGroup),
  .selectableAlarmGroup(selectableAlarmGroup), .overtravel(overtravel),
  .torqueCtrl(torqueCtrl), .motorSpeed(motorSpeed), .prmWrEn(prmWrEn),
  .prmWrIdx(prmWrIdx), .prmWrData(prmWrData),
  .brakeReleaseOut(brakeReleaseOut), .motorPowerOn(motorPowerOn),
  .zeroSpeedRef(zeroSpeedRef), .seqState(seqState)
);

// *** sim/bss_host.sv ***
// Host controller model: parameter access and command pulses
`timescale 1ns/1ps
module bss_host (
  // Clock and read data
  input  wire logic        mclk,
  input  wire logic [15:0] prmRdData,
  // Commands
  output logic             servoOnCmd,
  output logic             servoOffCmd,
  output logic             cfgRestart,
  // Parameter access
  output logic             prmWrEn,
  output logic      [1:0]  prmWrIdx,
  output logic      [15:0] prmWrData,
  output logic      [1:0]  prmRdIdx
);
  initial
  begin
    {cfgRestart, servoOffCmd, servoOnCmd, prmWrEn} = 4'h0;
    {prmWrIdx, prmRdIdx, prmWrData} = 20'h00000;
  end
  task wr(input logic [1:0] i, input logic [15:0] d);
    @(negedge mclk);
    {prmWrEn, prmWrIdx, prmWrData} = {1'b1, i, d};
    @(negedge mclk);
    {prmWrEn, prmWrData} = {1'b0, ~d};
  endtask : wr
  task rd(input logic [1:0] i, output logic [15:0] d);
    @(negedge mclk);
    prmRdIdx = i;
    @(negedge mclk);
    d = prmRdData;
  endtask : rd
  // Bit 0 servo on, bit 1 servo off, bit 2 restart
  task pulse(input logic [2:0] m);
    @(negedge mclk);
    {cfgRestart, servoOffCmd, servoOnCmd} = m;
    @(negedge mclk);
    {cfgRestart, servoOffCmd, servoOnCmd} = 3'h0;
  endtask : pulse
endmodule : bss_host

// *** sim/brake_and_stop_sequencer_tb.sv ***
// Self-checking bench for the brake and stop sequencer
`timescale 1ns/1ps
module brake_and_stop_sequencer_tb;
  // ==========================================================================
  // Signals
  localparam int STEP = 10;
  logic        mclk, resetn, coastAlarmGroup, selectableAlarmGroup;
  logic        overtravel, torqueCtrl, servoOnCmd, servoOffCmd, cfgRestart;
  logic        prmWrEn, brakeReleaseOut, motorPowerOn, zeroSpeedRef;
  logic [1:0]  prmWrIdx, prmRdIdx;
  logic [15:0] motorSpeed, prmWrData, prmRdData, rv, d;
  logic [4:0]  seqState;
  int          failures, n_compared, n;
  logic [15:0] rstv [4] = '{16'h0000, 16'h0064, 16'h0032, 16'h0000};

  bss_sequencer #(.STEP_CYCLES(STEP)) u_bss_sequencer (
    .mclk(mclk), .resetn(resetn), .servoOnCmd(servoOnCmd),
    .servoOffCmd(servoOffCmd), .cfgRestart(cfgRestart),
    .coastAlarmGroup(coastAlarmGroup),
    .selectableAlarmGroup(selectableAlarmGroup), .overtravel(overtravel),
    .torqueCtrl(torqueCtrl), .motorSpeed(motorSpeed), .prmWrEn(prmWrEn),
    .prmWrIdx(prmWrIdx), .prmWrData(prmWrData), .prmRdIdx(prmRdIdx),
    .prmRdData(prmRdData), .brakeReleaseOut(brakeReleaseOut),
    .motorPowerOn(motorPowerOn), .zeroSpeedRef(zeroSpeedRef),
    .seqState(seqState)
  );
  bss_host u_bss_host (
    .mclk(mclk), .prmRdData(prmRdData), .servoOnCmd(servoOnCmd),
    .servoOffCmd(servoOffCmd), .cfgRestart(cfgRestart), .prmWrEn(prmWrEn),
    .prmWrIdx(prmWrIdx), .prmWrData(prmWrData), .prmRdIdx(prmRdIdx)
  );

  // ==========================================================================
  // Helpers
  function logic [15:0] clampf(input logic [1:0] i, input logic [15:0] v);
    case (i)
      2'h0: return (v > 16'h0032) ? 16'h0032 : v;
      2'h1: return (v > 16'h2710) ? 16'h2710 : v;
      2'h2: return (v < 16'h000a) ? 16'h000a : (v > 16'h0064) ? 16'h0064 : v;
      default: return v;
    endcase
  endfunction : clampf
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task wait_st(input logic [4:0] s, input int lim);
    n = 0;
    while (seqState !== s && n < lim)
    begin
      @(negedge mclk);
      n++;
    end
  endtask : wait_st
  task go_run;
    u_bss_host.pulse(3'h1);
    chk("run", {seqState, brakeReleaseOut, motorPowerOn}, 16'h000b);
  endtask : go_run
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // Clock and watchdog
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // Overtravel toggles at random; the sequence must not depend on it
  always @(negedge mclk)
    overtravel <= 1'($urandom);
  initial
  begin
    #200000;
    failures++;
    wrap_up();
  end

  // ==========================================================================
  // Tests
  initial
  begin
    {resetn, coastAlarmGroup, selectableAlarmGroup} = 3'h0;
    {torqueCtrl, motorSpeed} = 17'h00000;
    failures = 0;
    n_compared = 0;
    void'($urandom(73146));
    repeat (16) @(negedge mclk);
    resetn = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      u_bss_host.rd(2'(i), rv);
      chk("reset value", rv, rstv[i]);
    end
    for (int k = 0; k < 16; k++)
    begin
      d = (k < 4) ? 16'hffff : (k < 8) ? 16'h0000 : 16'($urandom % 12000);
      u_bss_host.wr(2'(k), d);
      u_bss_host.rd(2'(k), rv);
      chk("register", rv, clampf(2'(k), d));
    end
    $display("test registers done");
    u_bss_host.wr(2'h3, 16'h0000);
    u_bss_host.pulse(3'h4);
    u_bss_host.wr(2'h0, 16'h0002);
    go_run();
    @(negedge mclk);
    while (overtravel !== 1'b1)
      @(negedge mclk);
    chk("overtravel", brakeReleaseOut, 16'h0001);
    u_bss_host.pulse(3'h2);
    chk("off", {brakeReleaseOut, motorPowerOn}, 16'h0001);
    wait_st(bss_pkg::BSS_IDLE, 100);
    chk("delay", 16'(n >= 2 * STEP && n <= 2 * STEP + 4), 16'h0001);
    u_bss_host.wr(2'h0, 16'h0032);
    go_run();
    u_bss_host.pulse(3'h2);
    coastAlarmGroup = 1'b1;
    @(negedge mclk);
    chk("alarm delay", {seqState, motorPowerOn}, 16'h0002);
    coastAlarmGroup = 1'b0;
    $display("test stopped done");
    u_bss_host.wr(2'h1, 16'h1f40);
    u_bss_host.wr(2'h2, 16'h0064);
    motorSpeed = -16'(6000 + $urandom % 4000);
    go_run();
    coastAlarmGroup = 1'b1;
    @(negedge mclk);
    chk("coast", {seqState, motorPowerOn}, 16'h0020);
    coastAlarmGroup = 1'b0;
    motorSpeed = -16'd6000;
    @(negedge mclk);
    chk("max", seqState, 16'h0010);
    motorSpeed = -16'd5999;
    @(negedge mclk);
    chk("below", {seqState, brakeReleaseOut}, 16'h0002);
    u_bss_host.wr(2'h1, 16'h0064);
    u_bss_host.wr(2'h2, 16'h0005);
    motorSpeed = 16'd3000;
    go_run();
    u_bss_host.pulse(3'h2);
    chk("off rot", {seqState, motorPowerOn, zeroSpeedRef}, 16'h0040);
    wait_st(bss_pkg::BSS_IDLE, 200);
    chk("wait", 16'(n >= 10 * STEP - 2 && n <= 10 * STEP + 4), 16'h0001);
    $display("test rotating done");
    go_run();
    selectableAlarmGroup = 1'b1;
    @(negedge mclk);
    chk("zero", {seqState, zeroSpeedRef}, 16'h0011);
    motorSpeed = 16'd0;
    @(negedge mclk);
    chk("halt", {seqState, brakeReleaseOut, motorPowerOn}, 16'h0004);
    selectableAlarmGroup = 1'b0;
    {torqueCtrl, motorSpeed} = {1'b1, 16'd3000};
    go_run();
    selectableAlarmGroup = 1'b1;
    @(negedge mclk);
    chk("torque", seqState, 16'h0010);
    {selectableAlarmGroup, torqueCtrl, motorSpeed} = 18'h00000;
    u_bss_host.wr(2'h3, 16'h0010);
    u_bss_host.pulse(3'h4);
    motorSpeed = 16'd3000;
    go_run();
    selectableAlarmGroup = 1'b1;
    @(negedge mclk);
    chk("digit", {seqState, zeroSpeedRef}, 16'h0020);
    {selectableAlarmGroup, motorSpeed} = 17'h00000;
    $display("test alarms done");
    wrap_up();
  end
endmodule : brake_and_stop_sequencer_tb
